// ### hw/scm_top.sv
// profile set select, multistep speed select and jerk-limited speed reference
// Summary of operation
// - no profile select assigned means profile set zero is always active
// - each profile select bit separately assignable; unassigned bit reads zero
// - select bits decode binary, bit one upper, to sets zero to three
// - zero jerk limit lets acceleration step in that segment
// - zero acceleration or deceleration limit removes that rate limit
// - four sets each hold own accel and decel limits, default 3.00
// - accel-in jerk bounds acceleration rise while speeding up
// - accel-out jerk bounds acceleration fall nearing commanded speed
// - decel-in jerk bounds deceleration rise while slowing
// - decel-out jerk bounds deceleration fall settling onto target speed
// - fifteen programmable speed presets selected by four select inputs
// - speed index zero is always zero speed, not writable
// - unassigned speed select bits read zero
// - new speed select pattern acted on after 50 ms stable
// - speed reference follows command within active profile limits
// - parameter and preset writes rejected while in run mode
//
// Chosen here: the address map and register access over Wishbone.
`default_nettype none
`include "scm_defs.svh"
module scm_top
  import scm_pkg::*;
#(
  parameter int unsigned STABLE_CYC = `SCM_STABLE_CYC, // input stable time
  parameter int unsigned UPD_CYC    = `SCM_UPD_CYC     // profile update tick
) (
  input  wire logic        core_clk,     // 20 MHz clock
  input  wire logic        rstn,         // async reset, active low
  input  wire logic        wb_cyc_i,     // wishbone cycle
  input  wire logic        wb_stb_i,     // wishbone strobe
  input  wire logic        wb_we_i,      // wishbone write
  input  wire logic [3:0]  wb_sel_i,     // byte enables
  input  wire logic [7:0]  wb_adr_i,     // byte address
  input  wire logic [31:0] wb_dat_i,     // write data
  output logic      [31:0] wb_dat_o,     // read data
  output logic             wb_ack_o,     // acknowledge
  input  wire logic [1:0]  prof_sel_pin, // profile select pins
  input  wire logic [3:0]  speed_sel_pin,// speed select pins
  output logic      [1:0]  active_set,   // active profile set
  output logic      [3:0]  active_index, // accepted speed index
  output logic signed [15:0] speed_ref   // speed reference
);
  // ==========================================================
  // register storage
  scm_prof_t       prof_reg [4];
  logic [15:0]     preset_reg [16];
  logic [7:0]      ctrl_reg;
  logic            ack_reg;
  logic [31:0]     rdat_reg;
  scm_wb_req_t     req;

  assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, sel: wb_sel_i,
                 adr: wb_adr_i, dat: wb_dat_i};

  // address decode
  wire        acc_go    = req.cyc & req.stb & ~ack_reg;
  wire        wr_go     = acc_go & req.we;
  wire        run_mode  = ctrl_reg[`SCM_CTRL_RUN];
  wire        hit_ctrl  = req.adr == `SCM_OFS_CTRL;
  wire        hit_prof  = req.adr[7:6] == 2'b01;
  wire        hit_pre   = req.adr[7:6] == 2'b10;
  wire [1:0]  w_set     = req.adr[5:4];
  wire [1:0]  w_pair    = req.adr[3:2];
  wire [3:0]  w_idx     = req.adr[5:2];
  wire        wr_lock   = run_mode;
  wire        wr_par    = wr_go & ~wr_lock;
  wire [15:0] lo_half   = {req.sel[1] ? req.dat[15:8] : 8'h00, req.sel[0] ? req.dat[7:0] : 8'h00};
  wire [15:0] hi_half   = {req.sel[3] ? req.dat[31:24] : 8'h00,
                           req.sel[2] ? req.dat[23:16] : 8'h00};

  // clamp a field to its documented range
  function automatic logic [15:0] scm_clamp(input logic [15:0] v, input logic [15:0] mx);
    scm_clamp = (v > mx) ? mx : v;
  endfunction : scm_clamp

  // control register and wishbone ack
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg <= 8'h00;
      ack_reg  <= 1'b0;
    end else begin
      ack_reg <= acc_go;
      if (wr_go && hit_ctrl && req.sel[0]) begin
        ctrl_reg <= req.dat[7:0];
      end
    end
  end

  // profile sets, reset to defaults, writes locked in run mode
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 4; i++) begin
        prof_reg[i] <= '{`SCM_RATE_DEF, `SCM_RATE_DEF, `SCM_JERK_DEF,
                         `SCM_JERK_DEF, `SCM_JERK_DEF, `SCM_JERK_DEF};
      end
    end else if (wr_par && hit_prof) begin
      unique case (w_pair)
        2'd0: begin
          prof_reg[w_set].accel <= scm_clamp(lo_half, `SCM_RATE_MAX);
          prof_reg[w_set].decel <= scm_clamp(hi_half, `SCM_RATE_MAX);
        end
        2'd1: begin
          prof_reg[w_set].jerk_ai <= scm_clamp(lo_half, `SCM_JERK_MAX);
          prof_reg[w_set].jerk_ao <= scm_clamp(hi_half, `SCM_JERK_MAX);
        end
        2'd2: begin
          prof_reg[w_set].jerk_di <= scm_clamp(lo_half, `SCM_JERK_MAX);
          prof_reg[w_set].jerk_do <= scm_clamp(hi_half, `SCM_JERK_MAX);
        end
        default: begin
        end
      endcase
    end
  end

  // speed presets; index zero has no storage write path
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 16; i++) begin
        preset_reg[i] <= `SCM_PRESET_DEF;
      end
    end else if (wr_par && hit_pre && w_idx != 4'd0) begin
      preset_reg[w_idx] <= lo_half;
    end
  end

  // ==========================================================
  // input synchronisers, three stages each
  logic [1:0] ps_s1, ps_s2, ps_s3;
  logic [3:0] ss_s1, ss_s2, ss_s3;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ps_s1 <= 2'b00;
      ps_s2 <= 2'b00;
      ps_s3 <= 2'b00;
      ss_s1 <= 4'h0;
      ss_s2 <= 4'h0;
      ss_s3 <= 4'h0;
    end else begin
      ps_s1 <= prof_sel_pin;
      ps_s2 <= ps_s1;
      ps_s3 <= ps_s2;
      ss_s1 <= speed_sel_pin;
      ss_s2 <= ss_s1;
      ss_s3 <= ss_s2;
    end
  end

  // profile and speed select masking and decode
  wire [1:0] ps_asg  = {ctrl_reg[`SCM_CTRL_ASG_SC1], ctrl_reg[`SCM_CTRL_ASG_SC0]};
  wire       ps_agree = ps_s2 == ps_s3;
  wire [1:0] prof_idx = ps_s3 & ps_asg;
  wire [3:0] ss_asg  = ctrl_reg[`SCM_CTRL_ASG_SPD +: 4];
  wire       ss_agree = ss_s2 == ss_s3;
  wire [3:0] ss_val  = ss_s3 & ss_asg;

  // active set latched once the last two synchroniser stages agree
  logic [1:0] set_reg;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      set_reg <= 2'd0;
    end else if (ps_agree) begin
      set_reg <= prof_idx;
    end
  end
  scm_prof_t act;
  assign act = prof_reg[set_reg];

  // speed select stability filter
  logic [3:0]  cand_reg;
  logic [31:0] stab_cnt;
  logic [3:0]  idx_reg;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cand_reg <= 4'h0;
      stab_cnt <= 32'h0000_0000;
      idx_reg  <= 4'h0;
    end else if (!ss_agree || ss_val != cand_reg) begin
      cand_reg <= ss_agree ? ss_val : cand_reg;
      stab_cnt <= 32'h0000_0000;
    end else if (stab_cnt < STABLE_CYC - 1) begin
      stab_cnt <= stab_cnt + 32'h0000_0001;
    end else begin
      idx_reg <= cand_reg;
    end
  end

  wire signed [15:0] target = (idx_reg == 4'd0) ? 16'sh0000
                                                : $signed(preset_reg[idx_reg]);

  // ==========================================================
  // s-curve generator, one step per update tick
  logic [31:0] tick_cnt;
  wire         tick = tick_cnt == UPD_CYC - 1;
  logic signed [15:0] ref_reg;
  logic signed [15:0] acc_reg;
  scm_phase_t  phase_reg;

  wire signed [17:0] err    = target - ref_reg;
  wire signed [17:0] lim_a = (act.accel == 16'h0000) ? 18'sh1_FFFF : {2'b00, act.accel};
  wire signed [17:0] lim_d = (act.decel == 16'h0000) ? 18'sh1_FFFF : {2'b00, act.decel};
  wire         up     = err > 0;
  wire signed [17:0] mag_e = up ? err : -err;
  wire signed [17:0] acc_m = (acc_reg < 0) ? -acc_reg : acc_reg;
  wire [15:0]  j_in   = up ? act.jerk_ai : act.jerk_di;
  wire [15:0]  j_out  = up ? act.jerk_ao : act.jerk_do;
  wire signed [17:0] lim  = up ? lim_a : lim_d;
  wire         near   = mag_e <= acc_m;
  wire signed [17:0] acc_tgt = near ? mag_e : lim;
  wire [15:0]  jstep  = (acc_tgt > acc_m) ? j_in : j_out;
  wire signed [17:0] rise = (jstep == 16'h0000) ? acc_tgt : acc_m + {2'b00, jstep};
  wire signed [17:0] fall = (jstep == 16'h0000) ? acc_tgt : acc_m - {2'b00, jstep};
  wire signed [17:0] acc_mn = (acc_tgt > acc_m) ? ((rise > acc_tgt) ? acc_tgt : rise)
                                                : ((fall < acc_tgt) ? acc_tgt : fall);
  wire signed [17:0] step  = (acc_mn > mag_e) ? mag_e : acc_mn;
  wire signed [17:0] ref_n = up ? ref_reg + step : ref_reg - step;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tick_cnt  <= 32'h0000_0000;
      ref_reg   <= 16'sh0000;
      acc_reg   <= 16'sh0000;
      phase_reg <= SCM_IDLE;
    end else begin
      tick_cnt <= tick ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
      if (tick) begin
        ref_reg   <= ref_n[15:0];
        acc_reg   <= up ? step[15:0] : -step[15:0];
        phase_reg <= (err == 0) ? SCM_IDLE : (up ? SCM_ACC : SCM_DEC);
      end
    end
  end

  // ==========================================================
  // read mux
  wire [31:0] rd_prof = (w_pair == 2'd0) ? {prof_reg[w_set].decel, prof_reg[w_set].accel}
                      : (w_pair == 2'd1) ? {prof_reg[w_set].jerk_ao, prof_reg[w_set].jerk_ai}
                      : (w_pair == 2'd2) ? {prof_reg[w_set].jerk_do, prof_reg[w_set].jerk_di}
                      : 32'h0000_0000;
  wire [31:0] rd_stat = {19'h0_0000, phase_reg, idx_reg, 2'b00, set_reg, 2'b00};
  wire [31:0] rd_mux  = hit_ctrl ? {24'h00_0000, ctrl_reg}
                      : (req.adr == `SCM_OFS_STATUS) ? rd_stat
                      : (req.adr == `SCM_OFS_SPEED_REF) ? {16'h0000, ref_reg}
                      : (req.adr == `SCM_OFS_ACCEL) ? {16'h0000, acc_reg}
                      : hit_prof ? rd_prof
                      : hit_pre ? {16'h0000, preset_reg[w_idx]}
                      : 32'h0000_0000;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rdat_reg <= 32'h0000_0000;
    end else if (acc_go) begin
      rdat_reg <= rd_mux;
    end
  end

  assign wb_ack_o     = ack_reg;
  assign wb_dat_o     = rdat_reg;
  assign active_set   = set_reg;
  assign active_index = idx_reg;
  assign speed_ref    = ref_reg;
endmodule : scm_top
`default_nettype wire

// ### hw/scm_defs.svh
// constants for the profile and multistep speed select block
`ifndef SCM_DEFS_SVH
`define SCM_DEFS_SVH
// ==========================================================
// register byte offsets
`define SCM_OFS_CTRL       8'h00
`define SCM_OFS_STATUS     8'h04
`define SCM_OFS_SPEED_REF  8'h08
`define SCM_OFS_ACCEL      8'h0C
`define SCM_OFS_PROF_BASE  8'h40
`define SCM_OFS_PRESET_BASE 8'h80
// ==========================================================
// field positions
`define SCM_CTRL_RUN       0
`define SCM_CTRL_ASG_SC0   1
`define SCM_CTRL_ASG_SC1   2
`define SCM_CTRL_ASG_SPD   4
// ==========================================================
// reset values and write limits, units of 0.01 ft/s2 and 0.1 ft/s3
`define SCM_RATE_DEF       16'h012C
`define SCM_RATE_MAX       16'h031F
`define SCM_JERK_DEF       16'h0050
`define SCM_JERK_MAX       16'h012B
`define SCM_PRESET_DEF     16'h0000
// ==========================================================
// timing
`define SCM_CLK_HZ         20000000
`define SCM_STABLE_MS      50
`define SCM_STABLE_CYC     ((`SCM_CLK_HZ / 1000) * `SCM_STABLE_MS)
`define SCM_UPD_CYC        20000
`endif

// ### hw/scm_pkg.sv
// types for the profile and multistep speed select block
`default_nettype none
package scm_pkg;
  // ==========================================================
  // one profile set
  typedef struct packed {
    logic [15:0] accel;
    logic [15:0] decel;
    logic [15:0] jerk_ai;
    logic [15:0] jerk_ao;
    logic [15:0] jerk_di;
    logic [15:0] jerk_do;
  } scm_prof_t;
  // wishbone request bundle
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } scm_wb_req_t;
  typedef enum logic [2:0] {
    SCM_IDLE  = 3'b001,
    SCM_ACC   = 3'b010,
    SCM_DEC   = 3'b100
  } scm_phase_t;
endpackage : scm_pkg
`default_nettype wire

// ### bench/scm_top_properties.sv
// port checker for the select block
`default_nettype none
module scm_chk
  import scm_pkg::*;
#(
  parameter int unsigned STABLE_CYC = 20 // pattern stable time
) (
  input wire logic               core_clk,      // clock
  input wire logic               rstn,          // reset, active low
  input wire logic               wb_cyc_i,      // bus cycle
  input wire logic               wb_stb_i,      // bus strobe
  input wire logic               wb_ack_o,      // bus ack
  input wire logic        [1:0]  prof_sel_pin,  // profile pins
  input wire logic        [3:0]  speed_sel_pin, // speed pins
  input wire logic        [1:0]  active_set,    // set in use
  input wire logic        [3:0]  active_index,  // accepted index
  input wire logic signed [15:0] speed_ref      // reference
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] p_cnt, s_cnt;
  logic [1:0]  p_prev;
  logic [3:0]  s_prev;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // ==========================================================
  // cycles each pin group has held still
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      p_cnt  <= 16'h0000;
      s_cnt  <= 16'h0000;
      p_prev <= 2'h0;
      s_prev <= 4'h0;
    end else begin
      p_prev <= prof_sel_pin;
      s_prev <= speed_sel_pin;
      p_cnt  <= (prof_sel_pin != p_prev) ? 16'h0000 : p_cnt + 16'(p_cnt != 16'hFFFF);
      s_cnt  <= (speed_sel_pin != s_prev) ? 16'h0000 : s_cnt + 16'(s_cnt != 16'hFFFF);
    end
  end
  // ==========================================================
  // properties
  property p_ack_follows; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  property p_ack_cause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
  property p_rst_quiet;
    disable iff (1'b0) !rstn |-> !wb_ack_o && active_set == 2'h0 && active_index == 4'h0;
  endproperty
  property p_set_masked; $stable(prof_sel_pin) [*6] |-> (active_set & ~prof_sel_pin) == 2'h0;
  endproperty
  property p_set_settle; $changed(active_set) |-> p_cnt >= 16'h0001; endproperty
  property p_idx_wait; $changed(active_index) |-> s_cnt >= 16'(STABLE_CYC - 2); endproperty
  property p_ref_idle; active_index == 4'h0 && speed_ref == 16'sh0000 |=> speed_ref == 16'sh0000;
  endproperty
  a_ack_follows : assert property (p_ack_follows) else $error("ack missing");
  a_ack_pulse : assert property (p_ack_pulse) else $error("ack too long");
  a_ack_cause : assert property (p_ack_cause) else $error("stray ack");
  a_rst_quiet : assert property (p_rst_quiet) else $error("busy in reset");
  a_set_masked : assert property (p_set_masked) else $error("set bit not driven");
  a_set_settle : assert property (p_set_settle) else $error("set not synced");
  a_idx_wait : assert property (p_idx_wait) else $error("index taken early");
  a_ref_idle : assert property (p_ref_idle) else $error("ref left zero");
  c_set3 : cover property (active_set == 2'h3);
  c_idx : cover property ($changed(active_index));
  c_ref : cover property (speed_ref > 16'sh0000);
endmodule : scm_chk
bind scm_top scm_chk #(.STABLE_CYC(STABLE_CYC)) chk_i (.core_clk(core_clk), .rstn(rstn),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .prof_sel_pin(prof_sel_pin),
  .speed_sel_pin(speed_sel_pin), .active_set(active_set), .active_index(active_index),
  .speed_ref(speed_ref));
`default_nettype wire

// ### bench/scm_car_ctl.sv
// car controller model driving the select pins
`default_nettype none
module scm_car_ctl
  import scm_pkg::*;
(
  input  wire logic       core_clk,      // drive clock
  input  wire logic [1:0] prof_want,     // wanted set
  input  wire logic [3:0] spd_want,      // wanted index
  output var  logic [1:0] prof_sel_pin,  // profile pins
  output var  logic [3:0] speed_sel_pin  // speed pins
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    prof_sel_pin  = 2'h0;
    speed_sel_pin = 4'h0;
  end
  // contacts move just after an edge and hold as levels
  always @(posedge core_clk) begin
    prof_sel_pin  <= prof_want;
    speed_sel_pin <= spd_want;
  end
endmodule : scm_car_ctl
`default_nettype wire

// ### bench/scm_top_test.sv
// self-checking bench for the select block
`default_nettype none
`include "scm_defs.svh"
module scm_top_test
  import scm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned STB = 20;
  logic core_clk, rstn, cyc, stb, we, wb_ack_o;
  logic [7:0] adr;
  logic [31:0] dat, wb_dat_o, rd;
  logic [1:0] prof_want, prof_sel_pin, active_set;
  logic [3:0] spd_want, speed_sel_pin, active_index;
  logic signed [15:0] speed_ref;
  logic [7:0] ctl_t [5] = '{8'h00, 8'h02, 8'h04, 8'h06, 8'h06};
  logic [1:0] pin_t [5] = '{2'h3, 2'h3, 2'h3, 2'h3, 2'h2};
  logic [1:0] exp_t [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h2};
  int n_fail, cmp_count;
  scm_top #(.STABLE_CYC(STB), .UPD_CYC(4)) DUT (.core_clk(core_clk), .rstn(rstn),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_sel_i(4'hF), .wb_adr_i(adr),
    .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .prof_sel_pin(prof_sel_pin),
    .speed_sel_pin(speed_sel_pin), .active_set(active_set), .active_index(active_index),
    .speed_ref(speed_ref));
  scm_car_ctl car (.core_clk(core_clk), .prof_want(prof_want), .spd_want(spd_want),
    .prof_sel_pin(prof_sel_pin), .speed_sel_pin(speed_sel_pin));
  initial begin
    forever #25 core_clk = ~core_clk;
  end
  task end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  // one classic cycle, held until ack is sampled
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge core_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 20) begin
      n_fail++;
      $display("Error %0t no ack from slave", $time);
      end_of_test();
    end
  endtask : wb
  task rdchk(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0000_0000);
    chk(rd, e);
  endtask : rdchk
  // bounded wait for index (r=0) or reference (r=1)
  task wait_out(input bit r, input logic [15:0] e);
    logic [15:0] v;
    for (int n = 0; n < 3000; n++) begin
      v = r ? speed_ref : {12'h000, active_index};
      if (v === e) break;
      @(posedge core_clk);
    end
    chk({16'h0000, v}, {16'h0000, e});
    // a wait that ran out ends the run
    if (v !== e) begin
      end_of_test();
    end
  endtask : wait_out
  // ==========================================================
  // main sequence
  initial begin
    core_clk = 1'b0;
    rstn = 1'b0;
    {cyc, stb, we, adr, dat} = '0;
    prof_want = 2'h0;
    spd_want = 4'h0;
    n_fail = 0;
    cmp_count = 0;
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    chk({10'h000, active_set, active_index, speed_ref}, 32'h0000_0000);
    for (int s = 0; s < 4; s++) begin
      rdchk(8'(8'h40 + s * 16), {`SCM_RATE_DEF, `SCM_RATE_DEF});
      rdchk(8'(8'h44 + s * 16), {`SCM_JERK_DEF, `SCM_JERK_DEF});
      rdchk(8'(8'h48 + s * 16), {`SCM_JERK_DEF, `SCM_JERK_DEF});
    end
    wb(1'b1, 8'h50, 32'hFFFF_0000);
    rdchk(8'h50, {`SCM_RATE_MAX, 16'h0000});
    wb(1'b1, 8'h54, 32'h0000_FFFF);
    rdchk(8'h54, {16'h0000, `SCM_JERK_MAX});
    wb(1'b1, 8'h80, 32'h0000_1234);
    rdchk(8'h80, 32'h0000_0000);
    wb(1'b1, 8'h94, 32'h0000_0064);
    wb(1'b1, 8'hB4, 32'h0000_0032);
    rdchk(8'h94, 32'h0000_0064);
    wb(1'b1, 8'h00, 32'h0000_0001);
    wb(1'b1, 8'h94, 32'h0000_0200);
    rdchk(8'h94, 32'h0000_0064);
    wb(1'b1, 8'h00, 32'h0000_0000);
    for (int i = 0; i < 5; i++) begin
      wb(1'b1, 8'h00, {24'h00_0000, ctl_t[i]});
      prof_want <= pin_t[i];
      repeat (8) @(posedge core_clk);
      chk({30'h0, active_set}, {30'h0, exp_t[i]});
    end
    wb(1'b1, 8'h00, 32'h0000_0070);
    spd_want <= 4'hD;
    repeat (STB / 2) @(posedge core_clk);
    chk({28'h0, active_index}, 32'h0000_0000);
    wait_out(1'b0, 16'h0005);
    wait_out(1'b1, 16'h0064);
    wb(1'b1, 8'h00, 32'h0000_00F0);
    wait_out(1'b0, 16'h000D);
    wait_out(1'b1, 16'h0032);
    spd_want <= 4'h0;
    wait_out(1'b0, 16'h0000);
    wait_out(1'b1, 16'h0000);
    // set one with zero accel limit and zero accel jerks: one update reaches the target
    wb(1'b1, 8'h54, 32'h0000_0000);
    wb(1'b1, 8'h00, 32'h0000_00F2);
    prof_want <= 2'h1;
    spd_want <= 4'h5;
    wait_out(1'b0, 16'h0005);
    chk({30'h0, active_set}, 32'h0000_0001);
    repeat (4) @(posedge core_clk);
    chk({16'h0000, speed_ref}, 32'h0000_0064);
    rdchk(8'h08, 32'h0000_0064);
    end_of_test();
  end
endmodule : scm_top_test
`default_nettype wire
